// [sfr_defs.vh]
// constants for the special function register bank
// assumes a single core clock and a 6-bit data-space register address
`ifndef SFR_DEFS_VH
`define SFR_DEFS_VH
// register offsets
`define SFR_TIMER_COUNT    6'h01
`define SFR_PC_LOW_BYTE    6'h02
`define SFR_CORE_FLAGS     6'h03
`define SFR_INDIRECT_PTR   6'h04
`define SFR_PORT_A_DATA    6'h05
`define SFR_PORT_B_DATA    6'h06
`define SFR_POWER_CONTROL  6'h08
`define SFR_CHANGE_WAKE    6'h09
`define SFR_PC_HIGH_STAGE  6'h0A
`define SFR_PULLDOWN_CTRL  6'h0B
// core_flags field positions
`define SFR_FLAG_C         0
`define SFR_FLAG_DC        1
`define SFR_FLAG_Z         2
`define SFR_FLAG_PD        3
`define SFR_FLAG_TO        4
`define SFR_FLAG_SPARE_LO  5
`define SFR_FLAG_SPARE_HI  6
`define SFR_FLAG_WAKE      7
// power_control field positions
`define SFR_POWER_CONTROL_WDT       7
`define SFR_POWER_CONTROL_IRQ_SEL   6
`define SFR_POWER_CONTROL_LVD       5
// option word field positions
`define SFR_OPT_SRC        5
`define SFR_OPT_EDGE       4
`define SFR_OPT_PSA        3
// reset values
`define SFR_RST_OPTION     6'h3F
`define SFR_RST_FLAGS      8'h18
`define SFR_RST_POWER_CONTROL       1'h0
`define SFR_RST_WAKE_EN    8'h00
`define SFR_RST_PULLDOWN   8'hFF
`define SFR_RST_PORT       8'h00
`define SFR_RST_PC         10'h000
// unimplemented bits
`define SFR_PTR_FILL       2'h3
`define SFR_POWER_CONTROL_FILL      5'h1F
`define SFR_PORT_B_IN_ONLY 8'hF7
// flag-affecting operation kinds
`define SFR_ALU_NONE       3'h0
`define SFR_ALU_ADD        3'h1
`define SFR_ALU_SUB        3'h2
`define SFR_ALU_ROT_LEFT   3'h3
`define SFR_ALU_ROT_RIGHT  3'h4
`define SFR_ALU_LOGIC      3'h5
`endif

// [sfr_bank.v]
// special function register bank: timer, program counter and stack,
// flags, pointer, port latches, power, wake and pull-down control
// assumes the decoder drives one-cycle strobes synchronous to CLOCK
`timescale 1ns/1ps
`include "sfr_defs.vh"

// Overview of operation
// - 8-bit timer, internal or external clock source
// - external clock counts on selected edge
// - prescaler on timer; timer write clears it
// - 10-bit PC, five-deep stack, upper bits hidden
// - PC advances on each instruction step unless modified
// - jump loads ten bits, staging untouched
// - call pushes current PC, loads ten bits
// - returns pop PC, staging untouched
// - PC low write takes upper from staging
// - staging never loaded from PC; 2 bits
// - computed flags override status write; TO/PD protected
// - add carry; subtract carry means no borrow
// - rotates load carry from source end bit
// - half carry from bit four
// - power-down and timeout flag set/clear events
// - wake bit marks change wake; spare bits storage
// - pointer uses six bits, top reads ones
// - port reads pins, writes latch; B3 input
// - power control enables; low bits read ones
// - irq select masks pin0 change path
// - per-pin change wake enables
// - active-low pull-down enables, bit7 storage
module sfr_bank #(
  parameter STACK_DEPTH = 5
) (
  input  wire        CLOCK,
  input  wire        RESET_N,
  input  wire        INSTR_STEP,
  input  wire        JUMP_OP,
  input  wire        CALL_OP,
  input  wire        RETURN_OP,
  input  wire [9:0]  TARGET_ADDR,
  input  wire        REG_WR,
  input  wire [5:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  output reg  [7:0]  REG_RDATA,
  input  wire [2:0]  ALU_KIND,
  input  wire [7:0]  ALU_A,
  input  wire [7:0]  ALU_B,
  input  wire        OPTION_WR,
  input  wire [7:0]  OPTION_DATA,
  input  wire        TIMER_EXT_CLOCK_PIN,
  input  wire        WATCHDOG_CLEAR_OP,
  input  wire        SLEEP_OP,
  input  wire        WDT_OVERFLOW,
  input  wire        WAKE_BY_CHANGE,
  input  wire [3:0]  PORT_A_PINS,
  input  wire [7:0]  PORT_B_PINS,
  output reg  [9:0]  PC_OUT,
  output reg  [5:0]  INDIRECT_ADDR,
  output reg         TIMER_OVERFLOW,
  output reg  [3:0]  PORT_A_OUT,
  output reg  [7:0]  PORT_B_OUT,
  output reg         WATCHDOG_ENABLE,
  output reg         LOW_VOLTAGE_DET_ENABLE,
  output reg         IRQ_PIN_SELECT,
  output reg  [7:0]  CHANGE_WAKE_ENABLE,
  output reg  [3:0]  PULLDOWN_N_PORT_A,
  output reg  [2:0]  PULLDOWN_N_PORT_B
);

  reg  [7:0] timer_count;
  reg  [7:0] prescaler;
  reg  [5:0] option_bits;
  reg        ext_pin_prev;
  reg  [1:0] pc_high_staging;
  reg  [7:0] core_flags;
  reg  [7:0] port_a_latch;
  reg  [7:0] change_wake_enable;
  reg  [7:0] pulldown_control;
  reg  [2:0] stack_ptr;
  reg  [9:0] stack_mem [0:STACK_DEPTH-1];

  wire wr_timer = REG_WR && (REG_ADDR == `SFR_TIMER_COUNT);
  wire wr_pcl   = REG_WR && (REG_ADDR == `SFR_PC_LOW_BYTE);
  wire wr_flags = REG_WR && (REG_ADDR == `SFR_CORE_FLAGS);
  wire wr_ptr   = REG_WR && (REG_ADDR == `SFR_INDIRECT_PTR);
  wire wr_pa    = REG_WR && (REG_ADDR == `SFR_PORT_A_DATA);
  wire wr_pb    = REG_WR && (REG_ADDR == `SFR_PORT_B_DATA);
  wire wr_power_control  = REG_WR && (REG_ADDR == `SFR_POWER_CONTROL);
  wire wr_wake  = REG_WR && (REG_ADDR == `SFR_CHANGE_WAKE);
  wire wr_stage = REG_WR && (REG_ADDR == `SFR_PC_HIGH_STAGE);
  wire wr_pdn   = REG_WR && (REG_ADDR == `SFR_PULLDOWN_CTRL);

  // timer clock source and edge
  wire src_ext  = option_bits[`SFR_OPT_SRC];
  wire edge_sel = option_bits[`SFR_OPT_EDGE];
  wire prescaler_assign      = option_bits[`SFR_OPT_PSA];
  // the pin is compared with its last sample, so each level must last at
  // least one clock; faster pin toggles are lost rather than miscounted
  wire ext_rise = TIMER_EXT_CLOCK_PIN & ~ext_pin_prev;
  wire ext_fall = ~TIMER_EXT_CLOCK_PIN & ext_pin_prev;
  wire ext_edge = edge_sel ? ext_fall : ext_rise;
  wire src_tick = src_ext ? ext_edge : INSTR_STEP;

  // prescaler tap: rate is two to the power (select + 1)
  reg  [7:0] pre_mask;
  always @* begin
    case (option_bits[2:0])
      3'h0:    pre_mask = 8'h01;
      3'h1:    pre_mask = 8'h03;
      3'h2:    pre_mask = 8'h07;
      3'h3:    pre_mask = 8'h0F;
      3'h4:    pre_mask = 8'h1F;
      3'h5:    pre_mask = 8'h3F;
      3'h6:    pre_mask = 8'h7F;
      default: pre_mask = 8'hFF;
    endcase
  end

  // when the prescaler belongs to the watchdog the timer sees every tick
  wire pre_full   = (prescaler & pre_mask) == pre_mask;
  wire timer_tick = src_tick && (prescaler_assign || pre_full);

  // flag computation
  wire [8:0] add_sum  = {1'b0, ALU_A} + {1'b0, ALU_B};
  wire [4:0] add_half = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]};
  wire [8:0] sub_sum  = {1'b0, ALU_A} + {1'b0, ~ALU_B} + 9'h001;
  wire [4:0] sub_half = {1'b0, ALU_A[3:0]} + {1'b0, ~ALU_B[3:0]} + 5'h01;

  reg  [2:0] alu_flags;
  reg  [2:0] alu_hit;
  always @* begin
    alu_flags = 3'h0;
    alu_hit   = 3'h0;
    case (ALU_KIND)
      `SFR_ALU_ADD: begin
        alu_flags = {add_sum[7:0] == 8'h00, add_half[4], add_sum[8]};
        alu_hit   = 3'h7;
      end
      `SFR_ALU_SUB: begin
        // carry and half carry read as "no borrow"
        alu_flags = {sub_sum[7:0] == 8'h00, sub_half[4], sub_sum[8]};
        alu_hit   = 3'h7;
      end
      `SFR_ALU_ROT_LEFT: begin
        alu_flags = {2'h0, ALU_A[7]};
        alu_hit   = 3'h1;
      end
      `SFR_ALU_ROT_RIGHT: begin
        alu_flags = {2'h0, ALU_A[0]};
        alu_hit   = 3'h1;
      end
      `SFR_ALU_LOGIC: begin
        alu_flags = {ALU_A == 8'h00, 2'h0};
        alu_hit   = 3'h4;
      end
      default: begin
        alu_flags = 3'h0;
        alu_hit   = 3'h0;
      end
    endcase
  end

  // any flag-affecting kind locks all three arithmetic bits, even those it
  // leaves alone, which keeps the lock decode to a single compare
  wire flags_locked = (ALU_KIND != `SFR_ALU_NONE);

  // next value of the arithmetic flags
  reg  [2:0] next_arith;
  integer    k;
  always @* begin
    next_arith = core_flags[2:0];
    for (k = 0; k < 3; k = k + 1) begin
      if (alu_hit[k]) begin
        next_arith[k] = alu_flags[k];
      end else if (wr_flags && !flags_locked) begin
        next_arith[k] = REG_WDATA[k];
      end
    end
  end

  // stack: circular index, deepest entry is overwritten on overflow
  // there is no overflow or underflow flag: a sixth nested call silently
  // loses the oldest return address, so software must bound its nesting
  wire [31:0] depth_last = STACK_DEPTH - 1;
  wire [2:0]  last_idx   = depth_last[2:0];
  wire [2:0]  ptr_up     = (stack_ptr == last_idx) ? 3'h0 : stack_ptr + 3'h1;
  wire [2:0]  ptr_down   = (stack_ptr == 3'h0) ? last_idx : stack_ptr - 3'h1;

  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g = g + 1) begin : g_stack
      always @(posedge CLOCK) begin
        if (!RESET_N) begin
          stack_mem[g] <= `SFR_RST_PC;
        end else if (CALL_OP && stack_ptr == g) begin
          stack_mem[g] <= PC_OUT;
        end
      end
    end
  endgenerate

  // program counter
  // priority follows the decoder: call, return, jump, low-byte write, step
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      PC_OUT    <= `SFR_RST_PC;
      stack_ptr <= 3'h0;
    end else if (CALL_OP) begin
      PC_OUT    <= TARGET_ADDR;
      stack_ptr <= ptr_up;
    end else if (RETURN_OP) begin
      PC_OUT    <= stack_mem[ptr_down];
      stack_ptr <= ptr_down;
    end else if (JUMP_OP) begin
      PC_OUT    <= TARGET_ADDR;
    end else if (wr_pcl) begin
      PC_OUT    <= {pc_high_staging, REG_WDATA};
    end else if (INSTR_STEP) begin
      PC_OUT    <= PC_OUT + 10'h001;
    end
  end

  // staging buffer: written only by software
  // only the two low bits exist; the upper six read back as zero
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      pc_high_staging <= 2'h0;
    end else if (wr_stage) begin
      pc_high_staging <= REG_WDATA[1:0];
    end
  end

  // timer and prescaler
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      timer_count    <= 8'h00;
      prescaler      <= 8'h00;
      option_bits    <= `SFR_RST_OPTION;
      ext_pin_prev   <= 1'b0;
      TIMER_OVERFLOW <= 1'b0;
    end else begin
      ext_pin_prev   <= TIMER_EXT_CLOCK_PIN;
      TIMER_OVERFLOW <= 1'b0;
      if (OPTION_WR) begin
        option_bits <= OPTION_DATA[5:0];
      end
      // a write wins over a tick in the same cycle
      if (wr_timer) begin
        timer_count <= REG_WDATA;
        if (!prescaler_assign) begin
          prescaler <= 8'h00;
        end
      end else begin
        if (src_tick && !prescaler_assign) begin
          prescaler <= pre_full ? 8'h00 : prescaler + 8'h01;
        end
        if (timer_tick) begin
          timer_count    <= timer_count + 8'h01;
          TIMER_OVERFLOW <= (timer_count == 8'hFF);
        end
      end
    end
  end

  // status flags
  // a watchdog overflow wins over clear or sleep for TO in the same cycle; PD still follows clear or sleep
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      core_flags <= `SFR_RST_FLAGS;
    end else begin
      core_flags[2:0] <= next_arith;
      if (WDT_OVERFLOW) begin
        core_flags[`SFR_FLAG_TO] <= 1'b0;
      end else if (WATCHDOG_CLEAR_OP || SLEEP_OP) begin
        core_flags[`SFR_FLAG_TO] <= 1'b1;
      end
      if (WATCHDOG_CLEAR_OP) begin
        core_flags[`SFR_FLAG_PD] <= 1'b1;
      end else if (SLEEP_OP) begin
        core_flags[`SFR_FLAG_PD] <= 1'b0;
      end
      if (wr_flags) begin
        core_flags[`SFR_FLAG_SPARE_HI] <= REG_WDATA[`SFR_FLAG_SPARE_HI];
        core_flags[`SFR_FLAG_SPARE_LO] <= REG_WDATA[`SFR_FLAG_SPARE_LO];
      end
      if (WAKE_BY_CHANGE) begin
        core_flags[`SFR_FLAG_WAKE] <= 1'b1;
      end
    end
  end

  // pointer, ports, power, wake and pull-down control
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      INDIRECT_ADDR          <= 6'h00;
      port_a_latch           <= `SFR_RST_PORT;
      PORT_B_OUT             <= `SFR_RST_PORT;
      WATCHDOG_ENABLE        <= `SFR_RST_POWER_CONTROL;
      IRQ_PIN_SELECT         <= 1'b0;
      LOW_VOLTAGE_DET_ENABLE <= 1'b0;
      change_wake_enable     <= `SFR_RST_WAKE_EN;
      pulldown_control       <= `SFR_RST_PULLDOWN;
    end else begin
      if (wr_ptr) begin
        INDIRECT_ADDR <= REG_WDATA[5:0];
      end
      if (wr_pa) begin
        port_a_latch <= REG_WDATA;
      end
      if (wr_pb) begin
        // pin 3 has no driver, so its latch bit is never kept
        PORT_B_OUT <= REG_WDATA & `SFR_PORT_B_IN_ONLY;
      end
      if (wr_power_control) begin
        WATCHDOG_ENABLE        <= REG_WDATA[`SFR_POWER_CONTROL_WDT];
        IRQ_PIN_SELECT         <= REG_WDATA[`SFR_POWER_CONTROL_IRQ_SEL];
        LOW_VOLTAGE_DET_ENABLE <= REG_WDATA[`SFR_POWER_CONTROL_LVD];
      end
      if (wr_wake) begin
        change_wake_enable <= REG_WDATA;
      end
      if (wr_pdn) begin
        pulldown_control <= REG_WDATA;
      end
    end
  end

  // derived outputs, one cycle behind their control registers
  // the lag is harmless for pad controls, which settle far slower than a clock
  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      PORT_A_OUT         <= 4'h0;
      CHANGE_WAKE_ENABLE <= 8'h00;
      PULLDOWN_N_PORT_A  <= 4'hF;
      PULLDOWN_N_PORT_B  <= 3'h7;
    end else begin
      PORT_A_OUT         <= port_a_latch[3:0];
      // pin 0 change detection is dropped while it serves as the irq pin
      CHANGE_WAKE_ENABLE <= change_wake_enable
                            & {7'h7F, ~IRQ_PIN_SELECT};
      PULLDOWN_N_PORT_A  <= pulldown_control[3:0];
      PULLDOWN_N_PORT_B  <= pulldown_control[6:4];
    end
  end

  // read mux, registered: data appears one cycle after the address
  // registering the read data costs a cycle of latency but keeps the long
  // address decode off the path into the datapath
  reg [7:0] next_rdata;
  always @* begin
    case (REG_ADDR)
      `SFR_TIMER_COUNT:   next_rdata = timer_count;
      `SFR_PC_LOW_BYTE:   next_rdata = PC_OUT[7:0];
      `SFR_CORE_FLAGS:    next_rdata = core_flags;
      `SFR_INDIRECT_PTR:  next_rdata = {`SFR_PTR_FILL, INDIRECT_ADDR};
      `SFR_PORT_A_DATA:   next_rdata = {port_a_latch[7:4], PORT_A_PINS};
      `SFR_PORT_B_DATA:   next_rdata = PORT_B_PINS;
      `SFR_POWER_CONTROL: next_rdata = {WATCHDOG_ENABLE, IRQ_PIN_SELECT,
                                        LOW_VOLTAGE_DET_ENABLE, `SFR_POWER_CONTROL_FILL};
      `SFR_CHANGE_WAKE:   next_rdata = change_wake_enable;
      `SFR_PC_HIGH_STAGE: next_rdata = {6'h00, pc_high_staging};
      `SFR_PULLDOWN_CTRL: next_rdata = pulldown_control;
      default:            next_rdata = 8'h00;
    endcase
  end

  always @(posedge CLOCK) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule // sfr_bank

// [sfr_bank_monitor.sv]
// concurrent checks on the register bank ports
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
`include "sfr_defs.vh"
module sfr_bank_monitor #(
  parameter STACK_DEPTH = 5
) (
  input wire       CLOCK,
  input wire       RESET_N,
  input wire       INSTR_STEP,
  input wire       JUMP_OP,
  input wire       CALL_OP,
  input wire       RETURN_OP,
  input wire [9:0] TARGET_ADDR,
  input wire       REG_WR,
  input wire [5:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire [9:0] PC_OUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  wire pc_op  = CALL_OP | RETURN_OP | JUMP_OP;
  wire pcl_wr = REG_WR && (REG_ADDR == `SFR_PC_LOW_BYTE);
  jump_load_a: assert property (
    JUMP_OP && !CALL_OP && !RETURN_OP |=> PC_OUT == $past(TARGET_ADDR))
    else $error("jump target not loaded");
  call_load_a: assert property (
    CALL_OP |=> PC_OUT == $past(TARGET_ADDR))
    else $error("call target not loaded");
  pc_step_a: assert property (
    INSTR_STEP && !pc_op && !pcl_wr |=> PC_OUT == $past(PC_OUT) + 10'h001)
    else $error("pc did not advance");
  pc_hold_a: assert property (
    !INSTR_STEP && !pc_op && !pcl_wr |=> $stable(PC_OUT))
    else $error("pc moved without cause");
  call_return_a: assert property (
    CALL_OP ##1 (RETURN_OP && !CALL_OP) |=> PC_OUT == $past(PC_OUT, 2))
    else $error("return did not restore pc");
  pcl_load_a: assert property (
    pcl_wr && !pc_op |=> PC_OUT[7:0] == $past(REG_WDATA))
    else $error("pc low write lost");
  ptr_fill_a: assert property (
    $past(RESET_N) && $past(REG_ADDR) == `SFR_INDIRECT_PTR |-> REG_RDATA[7:6] == 2'h3)
    else $error("pointer top bits not ones");
  power_control_fill_a: assert property (
    $past(RESET_N) && $past(REG_ADDR) == `SFR_POWER_CONTROL |-> REG_RDATA[4:0] == 5'h1F)
    else $error("power control low bits not ones");
  stage_fill_a: assert property (
    $past(RESET_N) && $past(REG_ADDR) == `SFR_PC_HIGH_STAGE |-> REG_RDATA[7:2] == 6'h00)
    else $error("staging top bits not zero");
  call_ret_c: cover property (CALL_OP ##1 RETURN_OP);
  pcl_wr_c: cover property (pcl_wr && !pc_op);
  step_c: cover property (INSTR_STEP [*3]);
endmodule // sfr_bank_monitor

bind sfr_bank sfr_bank_monitor #(.STACK_DEPTH(STACK_DEPTH)) i_mon (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .INSTR_STEP(INSTR_STEP), .JUMP_OP(JUMP_OP),
  .CALL_OP(CALL_OP), .RETURN_OP(RETURN_OP), .TARGET_ADDR(TARGET_ADDR), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PC_OUT(PC_OUT));

// [sfr_core_stub.sv]
// core-side model: issues a burst of instruction strobes
// assumes go is a one-cycle request taken only while idle
`timescale 1ns/1ps
module sfr_core_stub (
  input  wire       clock,
  input  wire       reset_n,
  input  wire       go,
  input  wire       slow,
  input  wire [7:0] count,
  output logic      step,
  output logic      busy
);
  logic [7:0] left;
  logic       gap;
  // slow mode leaves a dead cycle between strobes, like a stalled core
  always @(posedge clock) begin
    step <= 1'b0;
    if (!reset_n) begin
      busy <= 1'b0;
      gap <= 1'b0;
    end else if (go && !busy) begin
      left <= count;
      busy <= (count != 8'h00);
      gap <= slow;
    end else if (busy && gap) begin
      gap <= 1'b0;
    end else if (busy) begin
      step <= 1'b1;
      left <= left - 8'h01;
      busy <= (left != 8'h01);
      gap <= slow;
    end
  end
endmodule // sfr_core_stub

// [mcu_special_function_regs_test.sv]
// bench: drives the register bank and compares it with a queue-based model
// assumes sfr_core_stub supplies the instruction strobe
`timescale 1ns/1ps
`include "sfr_defs.vh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module mcu_special_function_regs_test;
  logic       clock = 0, reset_n = 0, jump_op = 0, call_op = 0, return_op = 0;
  logic       reg_wr = 0, option_wr = 0, ext_pin = 0, go = 0, slow = 0;
  logic       instr_step, busy, tovf, wde, lvde, irqs;
  logic [3:0] ev = 0, pins_a = 0, pao, pdna;
  logic [2:0] alu_kind = 0, pdnb;
  logic [5:0] reg_addr = 0, iaddr;
  logic [7:0] reg_wdata = 0, alu_a = 0, alu_b = 0, opt = 0, pins_b = 0, rdata, pbo, cwe;
  logic [7:0] steps_n = 0, mf = 8'h18, mt, d, e;
  logic [9:0] target = 0, pc, m_pc = 0;
  logic [9:0] m_stack[$];
  int         error_cnt = 0, checked = 0, ovf_cnt = 0;
  sfr_bank i_dut (
    .CLOCK(clock), .RESET_N(reset_n), .INSTR_STEP(instr_step), .JUMP_OP(jump_op),
    .CALL_OP(call_op), .RETURN_OP(return_op), .TARGET_ADDR(target), .REG_WR(reg_wr),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .ALU_KIND(alu_kind),
    .ALU_A(alu_a), .ALU_B(alu_b), .OPTION_WR(option_wr), .OPTION_DATA(opt),
    .TIMER_EXT_CLOCK_PIN(ext_pin), .WATCHDOG_CLEAR_OP(ev[0]), .SLEEP_OP(ev[1]),
    .WDT_OVERFLOW(ev[2]), .WAKE_BY_CHANGE(ev[3]), .PORT_A_PINS(pins_a),
    .PORT_B_PINS(pins_b), .PC_OUT(pc), .INDIRECT_ADDR(iaddr), .TIMER_OVERFLOW(tovf),
    .PORT_A_OUT(pao), .PORT_B_OUT(pbo), .WATCHDOG_ENABLE(wde),
    .LOW_VOLTAGE_DET_ENABLE(lvde), .IRQ_PIN_SELECT(irqs), .CHANGE_WAKE_ENABLE(cwe),
    .PULLDOWN_N_PORT_A(pdna), .PULLDOWN_N_PORT_B(pdnb));
  sfr_core_stub i_core (.clock(clock), .reset_n(reset_n), .go(go), .slow(slow),
    .count(steps_n), .step(instr_step), .busy(busy));
  always #5 clock = ~clock;
  always @(posedge clock) if (tovf === 1'b1) ovf_cnt++;
  task automatic wrap_up;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] v, logic o = 0);
    @(posedge clock);
    reg_wr <= !o;
    option_wr <= o;
    reg_addr <= a;
    reg_wdata <= v;
    opt <= v;
    @(posedge clock);
    reg_wr <= 0;
    option_wr <= 0;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] x, string n);
    @(posedge clock);
    reg_addr <= a;
    repeat (2) @(posedge clock);
    #1;
    `CHK(n, x, rdata)
  endtask
  // back-to-back strobes are legal, so one task drives jump, call and return alike
  task automatic pc_op(int k, logic [9:0] t);
    @(posedge clock);
    target <= t;
    jump_op <= (k == 0);
    call_op <= (k == 1);
    return_op <= (k == 2);
    @(posedge clock);
    {jump_op, call_op, return_op} <= 3'h0;
    #1;
    if (k == 1) m_stack.push_front(m_pc);
    m_pc = (k == 2) ? m_stack.pop_front() : t;
    `CHK("pc", m_pc, pc)
  endtask
  task automatic run(int n, logic s);
    int w;
    @(posedge clock);
    steps_n <= n[7:0];
    slow <= s;
    go <= 1;
    @(posedge clock);
    go <= 0;
    #1;
    w = 0;
    while ((busy !== 1'b0 || instr_step !== 1'b0) && w < 600) begin
      @(posedge clock);
      #1;
      w++;
    end
    m_pc = m_pc + n[9:0];
    `CHK("pc", m_pc, pc)
    if (w == 600) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic alu(int k, logic [7:0] a, logic [7:0] b);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    bb = (k == 2) ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, k == 2};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, k == 2};
    @(posedge clock);
    alu_kind <= k[2:0];
    alu_a <= a;
    alu_b <= b;
    reg_wr <= 1;
    reg_addr <= `SFR_CORE_FLAGS;
    reg_wdata <= ~mf;
    @(posedge clock);
    alu_kind <= 3'h0;
    reg_wr <= 0;
    mf[6:5] = ~mf[6:5];
    if (k < 3) mf[2:0] = {s[7:0] == 8'h00, h[4], s[8]};
    if (k == 3) mf[0] = a[7];
    if (k == 4) mf[0] = a[0];
    if (k == 5) mf[2] = (a == 8'h00);
    rd(`SFR_CORE_FLAGS, mf, "flags");
  endtask
  task automatic pulse(int k);
    @(posedge clock);
    ev[k] <= 1'b1;
    @(posedge clock);
    ev[k] <= 1'b0;
    case (k)
      0: mf[4:3] = 2'h3;
      1: mf[4:3] = 2'h2;
      2: mf[4] = 1'b0;
      default: mf[7] = 1'b1;
    endcase
    rd(`SFR_CORE_FLAGS, mf, "flags");
  endtask
  initial begin
    void'($urandom(32'hB7EA));
    repeat (20) @(posedge clock);
    reset_n <= 1;
    rd(`SFR_CORE_FLAGS, 8'h18, "flags");
    rd(`SFR_PULLDOWN_CTRL, 8'hFF, "pulldown_control");
    for (int r = 0; r < 3; r++) begin
      d = $urandom;
      e = $urandom;
      @(posedge clock);
      pins_a <= d[3:0];
      pins_b <= e;
      wr(`SFR_INDIRECT_PTR, d);
      rd(`SFR_INDIRECT_PTR, {2'h3, d[5:0]}, "ptr");
      `CHK("iaddr", d[5:0], iaddr)
      wr(`SFR_POWER_CONTROL, d);
      wr(`SFR_CHANGE_WAKE, e);
      rd(`SFR_POWER_CONTROL, {d[7:5], 5'h1F}, "power_control");
      `CHK("enables", {d[7], d[5], d[6]}, {wde, lvde, irqs})
      rd(`SFR_CHANGE_WAKE, e, "change_wake_enable");
      `CHK("wake_en", {e[7:1], e[0] & ~d[6]}, cwe)
      wr(`SFR_PULLDOWN_CTRL, d);
      rd(`SFR_PULLDOWN_CTRL, d, "pulldown_control");
      `CHK("pulldown", d[6:0], {pdnb, pdna})
      wr(`SFR_PORT_A_DATA, e);
      rd(`SFR_PORT_A_DATA, {e[7:4], d[3:0]}, "port_a_data");
      wr(`SFR_PORT_B_DATA, d);
      rd(`SFR_PORT_B_DATA, e, "port_b_data");
      `CHK("latches", {d & 8'hF7, e[3:0]}, {pbo, pao})
      wr(6'h07, d);
      rd(6'h07, 8'h00, "unmapped");
      wr(`SFR_CORE_FLAGS, d);
      mf = {mf[7], d[6:5], mf[4:3], d[2:0]};
      rd(`SFR_CORE_FLAGS, mf, "flags");
    end
    alu(1, 8'hFF, 8'h01);
    for (int k = 1; k < 6; k++)
      repeat (3) alu(k, $urandom, $urandom);
    for (int k = 0; k < 4; k++) pulse(k);
    pulse(2);
    pulse(0);
    run(7, 1'b0);
    run(9, 1'b1);
    pc_op(0, $urandom);
    rd(`SFR_PC_LOW_BYTE, m_pc[7:0], "pcl");
    for (int k = 0; k < 5; k++) pc_op(1, $urandom);
    for (int k = 0; k < 5; k++) pc_op(2, 10'h000);
    // call answered by a return on the very next edge
    @(posedge clock);
    target <= $urandom;
    call_op <= 1'b1;
    @(posedge clock);
    call_op <= 1'b0;
    return_op <= 1'b1;
    @(posedge clock);
    return_op <= 1'b0;
    #1;
    `CHK("pc", m_pc, pc)
    pc_op(1, $urandom);
    pc_op(2, 10'h000);
    d = $urandom;
    e = $urandom;
    wr(`SFR_PC_HIGH_STAGE, d);
    pc_op(0, 10'h3FF);
    wr(`SFR_PC_LOW_BYTE, e);
    rd(`SFR_PC_HIGH_STAGE, {6'h00, d[1:0]}, "stage");
    m_pc = {d[1:0], e};
    `CHK("pc", m_pc, pc)
    wr(6'h00, 8'h08, 1'b1);
    wr(`SFR_TIMER_COUNT, 8'hFD);
    run(5, 1'b1);
    rd(`SFR_TIMER_COUNT, 8'h02, "timer");
    `CHK("overflows", 1, ovf_cnt)
    wr(6'h00, 8'h00, 1'b1);
    wr(`SFR_TIMER_COUNT, 8'h10);
    run(6, 1'b0);
    rd(`SFR_TIMER_COUNT, 8'h13, "timer");
    wr(6'h00, 8'h01, 1'b1);
    wr(`SFR_TIMER_COUNT, 8'h20);
    run(8, 1'b0);
    rd(`SFR_TIMER_COUNT, 8'h22, "timer");
    for (int m = 0; m < 2; m++) begin
      wr(6'h00, (m == 0) ? 8'h28 : 8'h38, 1'b1);
      wr(`SFR_TIMER_COUNT, 8'h00);
      mt = 8'h00;
      repeat (12) begin
        d = $urandom;
        @(posedge clock);
        ext_pin <= d[0];
        if (d[0] != ext_pin && d[0] == (m == 0)) mt++;
        @(posedge clock);
      end
      rd(`SFR_TIMER_COUNT, mt, "timer");
    end
    // second reset in mid-run: wake bit must drop back to zero
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    m_pc = 10'h000;
    mf = 8'h18;
    rd(`SFR_CORE_FLAGS, mf, "flags");
    `CHK("pc", m_pc, pc)
    `CHK("wake_en", 8'h00, cwe)
    wrap_up();
  end
endmodule // mcu_special_function_regs_test
